// *** core/spcb_afifo.sv ***
`default_nettype none
// ====================================================================
// Asynchronous FIFO, gray pointers, two-stage synchronisers
module spcb_afifo #(
    parameter int unsigned W = 32,
    parameter int unsigned AW = 3
) (
    input wire logic wclk,
    input wire logic wrst_n,
    input wire logic wce,
    spcb_stream_if.snk wr,
    input wire logic rclk,
    input wire logic rrst_n,
    input wire logic rce,
    spcb_stream_if.src rd
);
    logic [W-1:0] mem [2**AW];
    logic [AW:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
    logic [AW:0] w2r_a_ff, w2r_b_ff, r2w_a_ff, r2w_b_ff;
    wire [AW:0] nxt_wbin = wbin_ff + (AW+1)'(1);
    wire [AW:0] nxt_rbin = rbin_ff + (AW+1)'(1);
    // Full compares gray write pointer with inverted top bits of read
    wire full = (wgray_ff == {~r2w_b_ff[AW:AW-1], r2w_b_ff[AW-2:0]});
    wire empty = (rgray_ff == w2r_b_ff);
    wire do_wr = wce & wr.valid & ~full;
    wire do_rd = rce & ~empty & rd.ready;
    assign wr.ready = ~full;
    assign rd.valid = ~empty;
    assign rd.data = mem[rbin_ff[AW-1:0]];

    // Write domain: storage, pointer and synchroniser of read pointer
    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin_ff <= '0;
            wgray_ff <= '0;
            r2w_a_ff <= '0;
            r2w_b_ff <= '0;
        end else if (wce) begin
            r2w_a_ff <= rgray_ff;
            r2w_b_ff <= r2w_a_ff;
            if (do_wr) begin
                wbin_ff <= nxt_wbin;
                wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
            end
        end
    end
    always_ff @(posedge wclk) begin
        if (do_wr) begin
            mem[wbin_ff[AW-1:0]] <= wr.data;
        end
    end

    // Read domain: pointer and synchroniser of write pointer
    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin_ff <= '0;
            rgray_ff <= '0;
            w2r_a_ff <= '0;
            w2r_b_ff <= '0;
        end else if (rce) begin
            w2r_a_ff <= wgray_ff;
            w2r_b_ff <= w2r_a_ff;
            if (do_rd) begin
                rbin_ff <= nxt_rbin;
                rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
            end
        end
    end
endmodule : spcb_afifo
`default_nettype wire

// *** core/spcb_bridge.sv ***
`default_nettype none
// ====================================================================
// Stream port clocking bridge: application side to transport pipe
//
// Function
// - All stream port signals are synchronous to one application clock.
// - Application clock is transport clock times a rational factor from a set.
// - Transport pipe carries at most one word per transport clock cycle.
// - Fast application side is throttled by ready and valid, no loss or duplication.
// - Baseline revision: a narrow word occupies a full transport slot.
// - Narrow slots reduce bandwidth left to competing streams.
// - Enhanced revision packs narrow words into full transport slots.
// - Crossing FIFOs sit in the bridge, none needed in the application.
// - Ports carry only data, valid and ready, no last marker.
module spcb_bridge
    import spcb_pkg::*;
#(
    parameter int unsigned WORD_W = SPCB_WORD_W,
    parameter int unsigned NARROW_W = SPCB_NARROW_W,
    parameter int unsigned FIFO_AW = SPCB_FIFO_AW,
    parameter logic [15:0] CLK_MUL = SPCB_MUL_DEFAULT,
    parameter logic [15:0] CLK_DIV = SPCB_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic application_clock_input,
    input wire logic enhanced_pack,
    input wire logic [WORD_W-1:0] wide_tdata,
    input wire logic wide_tvalid,
    output logic wide_tready,
    input wire logic [NARROW_W-1:0] narrow_tdata,
    input wire logic narrow_tvalid,
    output logic narrow_tready,
    output logic [WORD_W-1:0] pipe_word,
    output logic pipe_valid,
    output logic pipe_narrow,
    output logic generator_output_clock,
    output logic [15:0] generator_mul,
    output logic [15:0] generator_div
);
    // ================================================================
    // Reset release: transport domain and application domain
    logic rst_a_ff, rst_b_ff, arst_a_ff, arst_b_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    always_ff @(posedge application_clock_input or negedge rst_n) begin
        if (!rst_n) begin
            arst_a_ff <= 1'b0;
            arst_b_ff <= 1'b0;
        end else begin
            arst_a_ff <= 1'b1;
            arst_b_ff <= arst_a_ff;
        end
    end
    wire srst_n = rst_b_ff;
    wire arst_n = arst_b_ff;

    // Clock enable reaches the application domain through two stages;
    // a third stage lets ready fall one edge before the domain freezes,
    // so a frozen ready can never show a take that is not stored
    logic ce_a_ff, ce_b_ff, ce_c_ff;
    always_ff @(posedge application_clock_input or negedge arst_n) begin
        if (!arst_n) begin
            ce_a_ff <= 1'b0;
            ce_b_ff <= 1'b0;
            ce_c_ff <= 1'b0;
        end else begin
            ce_a_ff <= ce;
            ce_b_ff <= ce_a_ff;
            ce_c_ff <= ce_b_ff;
        end
    end
    wire ace = ce_c_ff;

    // Packing mode is a static strap, synchronised into the app domain
    logic pk_a_ff, pk_b_ff;
    always_ff @(posedge application_clock_input or negedge arst_n) begin
        if (!arst_n) begin
            pk_a_ff <= 1'b0;
            pk_b_ff <= 1'b0;
        end else begin
            pk_a_ff <= enhanced_pack;
            pk_b_ff <= pk_a_ff;
        end
    end

    // ================================================================
    // Rational clock generator settings and a reference output
    // The real multiplier is analog; here the ratio is clamped to the
    // allowed set and a divided transport clock stands in for it.
    localparam logic [15:0] MUL_OK = (CLK_MUL == 16'h0000) ? SPCB_MUL_DEFAULT
        : (CLK_MUL > SPCB_RATIO_MAX) ? SPCB_RATIO_MAX : CLK_MUL;
    localparam logic [15:0] DIV_OK = (CLK_DIV == 16'h0000) ? SPCB_DIV_DEFAULT
        : (CLK_DIV > SPCB_RATIO_MAX) ? SPCB_RATIO_MAX : CLK_DIV;
    logic [15:0] gcnt_ff, nxt_gcnt;
    logic gclk_ff;
    assign nxt_gcnt = (gcnt_ff >= DIV_OK - 16'h0001) ? 16'h0000 : gcnt_ff + 16'h0001;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            gcnt_ff <= 16'h0000;
            gclk_ff <= 1'b0;
            generator_mul <= SPCB_MUL_DEFAULT;
            generator_div <= SPCB_DIV_DEFAULT;
        end else if (ce) begin
            gcnt_ff <= nxt_gcnt;
            if (nxt_gcnt == 16'h0000) begin
                gclk_ff <= ~gclk_ff;
            end
            generator_mul <= MUL_OK;
            generator_div <= DIV_OK;
        end
    end
    assign generator_output_clock = gclk_ff;

    // ================================================================
    // Narrow packer on the application clock (enhanced revision)
    logic [WORD_W-1:0] pack_ff;
    logic [1:0] lane_ff;
    logic pk_full_ff;
    spcb_stream_if #(.W(WORD_W)) wq ();
    spcb_stream_if #(.W(WORD_W + 1)) nq ();
    spcb_stream_if #(.W(WORD_W)) wpipe ();
    spcb_stream_if #(.W(WORD_W + 1)) npipe ();
    wire packing = pk_b_ff;
    // Packer stalls while its full word waits for the FIFO, and for one edge after each take
    wire nar_take = ace & narrow_tvalid & narrow_tready;
    wire pk_flush = pk_full_ff & nq.ready;
    wire [WORD_W-1:0] nar_wide = {{(WORD_W-NARROW_W){1'b0}}, narrow_tdata};
    always_ff @(posedge application_clock_input or negedge arst_n) begin
        if (!arst_n) begin
            pack_ff <= '0;
            lane_ff <= SPCB_LANE_ZERO;
            pk_full_ff <= 1'b0;
        end else if (ace) begin
            if (pk_flush) begin
                pk_full_ff <= 1'b0;
            end
            if (nar_take && packing) begin
                pack_ff[lane_ff*NARROW_W +: NARROW_W] <= narrow_tdata;
                lane_ff <= lane_ff + SPCB_LANE_ONE;
                if (lane_ff == SPCB_LANE_LAST) begin
                    pk_full_ff <= 1'b1;
                end
            end
        end
    end
    // Baseline: each narrow byte goes alone in a full slot
    assign nq.valid = packing ? pk_full_ff : nar_take;
    assign nq.data = packing ? {1'b1, pack_ff} : {1'b1, nar_wide};
    assign wq.valid = ace & wide_tvalid & wide_tready;
    assign wq.data = wide_tdata;

    // Ready outputs registered: ready only with a free FIFO entry, or in packing mode with the packer not full
    always_ff @(posedge application_clock_input or negedge arst_n) begin
        if (!arst_n) begin
            wide_tready <= 1'b0;
            narrow_tready <= 1'b0;
        end else if (ace) begin
            wide_tready <= ce_b_ff & wq.ready & ~(wide_tvalid & wide_tready);
            narrow_tready <= ce_b_ff & (packing ? ~pk_full_ff & ~nar_take
                : nq.ready & ~(narrow_tvalid & narrow_tready));
        end
    end

    // ================================================================
    // Crossing FIFOs: application clock in, transport clock out
    spcb_afifo #(.W(WORD_W), .AW(FIFO_AW)) u_wide_fifo (
        .wclk(application_clock_input),
        .wrst_n(arst_n),
        .wce(ace),
        .wr(wq),
        .rclk(clk),
        .rrst_n(srst_n),
        .rce(ce),
        .rd(wpipe)
    );
    spcb_afifo #(.W(WORD_W + 1), .AW(FIFO_AW)) u_narrow_fifo (
        .wclk(application_clock_input),
        .wrst_n(arst_n),
        .wce(ace),
        .wr(nq),
        .rclk(clk),
        .rrst_n(srst_n),
        .rce(ce),
        .rd(npipe)
    );

    // ================================================================
    // Transport arbiter: one word per cycle, alternating on contention
    spcb_arb_t last_ff;
    wire pick_n = npipe.valid & (~wpipe.valid | last_ff == SPCB_ARB_WIDE);
    wire pick_w = wpipe.valid & ~pick_n;
    assign wpipe.ready = pick_w;
    assign npipe.ready = pick_n;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            last_ff <= SPCB_ARB_WIDE;
            pipe_word <= '0;
            pipe_valid <= 1'b0;
            pipe_narrow <= 1'b0;
        end else if (ce) begin
            pipe_valid <= pick_w | pick_n;
            pipe_narrow <= pick_n;
            pipe_word <= pick_n ? npipe.data[WORD_W-1:0] : wpipe.data;
            if (pick_n) begin
                last_ff <= SPCB_ARB_NARROW;
            end else if (pick_w) begin
                last_ff <= SPCB_ARB_WIDE;
            end
        end
    end
endmodule : spcb_bridge
`default_nettype wire

// *** core/spcb_pkg.sv ***
`default_nettype none
// ====================================================================
// Shared constants and types of the stream port clocking bridge
package spcb_pkg;
    localparam int unsigned SPCB_WORD_W = 32;
    localparam int unsigned SPCB_NARROW_W = 8;
    localparam int unsigned SPCB_LANES = SPCB_WORD_W / SPCB_NARROW_W;
    localparam int unsigned SPCB_FIFO_AW = 3;
    localparam int unsigned SPCB_SYNC_STAGES = 2;
    localparam logic [15:0] SPCB_MUL_DEFAULT = 16'h0003;
    localparam logic [15:0] SPCB_DIV_DEFAULT = 16'h0002;
    localparam logic [15:0] SPCB_RATIO_MAX = 16'h0040;
    localparam logic [1:0] SPCB_LANE_ZERO = 2'h0;
    localparam logic [1:0] SPCB_LANE_LAST = 2'h3;
    localparam logic [1:0] SPCB_LANE_ONE = 2'h1;
    typedef enum logic [1:0] {SPCB_ARB_WIDE, SPCB_ARB_NARROW} spcb_arb_t;
endpackage : spcb_pkg
`default_nettype wire

// *** core/spcb_stream_if.sv ***
`default_nettype none
// ====================================================================
// Word stream with valid and ready between bridge modules
interface spcb_stream_if #(
    parameter int unsigned W = 32
);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : spcb_stream_if
`default_nettype wire

// *** sim/spcb_app_src.sv ***
`default_nettype none
// ==================
// Application logic model feeding both streams from queues
module spcb_app_src
    import spcb_pkg::*;
(
    input wire logic aclk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic wide_tready,
    input wire logic narrow_tready,
    output logic [SPCB_WORD_W-1:0] wide_tdata,
    output logic wide_tvalid,
    output logic [SPCB_NARROW_W-1:0] narrow_tdata,
    output logic narrow_tvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SPCB_WORD_W-1:0] wq[$];
    logic [SPCB_NARROW_W-1:0] nq[$];
    logic idle_ff;
    // Application clock only; idle lines toggle so stale data never looks valid
    always @(posedge aclk or negedge rst_n) begin
        if (!rst_n) begin
            {wide_tvalid, narrow_tvalid, idle_ff, wide_tdata, narrow_tdata} <= '0;
        end else begin
            idle_ff <= slow & ~idle_ff;
            if (!wide_tvalid || wide_tready) begin
                wide_tvalid <= wq.size() > 0 && !idle_ff;
                wide_tdata <= (wq.size() > 0 && !idle_ff) ? wq.pop_front() : ~wide_tdata;
            end
            if (!narrow_tvalid || narrow_tready) begin
                narrow_tvalid <= nq.size() > 0 && !idle_ff;
                narrow_tdata <= (nq.size() > 0 && !idle_ff) ? nq.pop_front() : ~narrow_tdata;
            end
        end
    end
endmodule : spcb_app_src
`default_nettype wire

// *** sim/spcb_bridge_asserts.sv ***
`default_nettype none
// ==================
// Port checks of the bridge
module spcb_bridge_asserts
    import spcb_pkg::*;
#(
    parameter logic [15:0] CLK_MUL = 16'h0003,
    parameter logic [15:0] CLK_DIV = 16'h0002
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic application_clock_input,
    input wire logic enhanced_pack,
    input wire logic wide_tvalid,
    input wire logic wide_tready,
    input wire logic narrow_tvalid,
    input wire logic narrow_tready,
    input wire logic [SPCB_WORD_W-1:0] pipe_word,
    input wire logic pipe_valid,
    input wire logic pipe_narrow,
    input wire logic generator_output_clock,
    input wire logic [15:0] generator_mul,
    input wire logic [15:0] generator_div
);
    timeunit 1ns;
    timeprecision 1ps;
    // A take is valid and ready together on one application edge
    sequence s_wide_take;
        wide_tvalid && wide_tready;
    endsequence
    sequence s_narrow_take;
        narrow_tvalid && narrow_tready;
    endsequence
    chk_wide_gap: assert property (@(posedge application_clock_input)
        disable iff (!rst_n) s_wide_take |=> !wide_tready)
        else $error("wide ready held after a take");
    chk_narrow_gap: assert property (@(posedge application_clock_input)
        disable iff (!rst_n) s_narrow_take |=> !narrow_tready)
        else $error("narrow ready held after a take");
    chk_rst_ready: assert property (@(posedge application_clock_input)
        disable iff (!rst_n) $rose(rst_n) |-> (!wide_tready && !narrow_tready) [*3])
        else $error("ready too early after reset");
    chk_base_zero: assert property (@(posedge clk) disable iff (!rst_n)
        pipe_valid && pipe_narrow && !enhanced_pack |-> pipe_word[31:8] == 24'h00_0000)
        else $error("baseline narrow slot has upper bits");
    chk_ratio_fix: assert property (@(posedge clk) disable iff (!rst_n)
        generator_mul == CLK_MUL && generator_div == CLK_DIV)
        else $error("generator ratio differs from setting");
    chk_ratio_range: assert property (@(posedge clk) disable iff (!rst_n)
        generator_div != 16'h0000 && generator_mul <= SPCB_RATIO_MAX)
        else $error("generator ratio out of range");
    // Divider output toggles every CLK_DIV transport cycles, here two
    chk_gen_toggle: assert property (@(posedge clk) disable iff (!rst_n || !ce)
        $changed(generator_output_clock) |=> $stable(generator_output_clock)
        ##1 $changed(generator_output_clock))
        else $error("generator clock period wrong");
    chk_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        !ce && !$past(ce) |-> $stable(pipe_word) && $stable(pipe_valid))
        else $error("pipe moved while clock enable low");
endmodule : spcb_bridge_asserts
bind spcb_bridge spcb_bridge_asserts #(.CLK_MUL(CLK_MUL), .CLK_DIV(CLK_DIV)) u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .application_clock_input(application_clock_input),
    .enhanced_pack(enhanced_pack), .wide_tvalid(wide_tvalid), .wide_tready(wide_tready),
    .narrow_tvalid(narrow_tvalid), .narrow_tready(narrow_tready), .pipe_word(pipe_word),
    .pipe_valid(pipe_valid), .pipe_narrow(pipe_narrow),
    .generator_output_clock(generator_output_clock), .generator_mul(generator_mul),
    .generator_div(generator_div));
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
// ==================
// Bench for the stream port clocking bridge
module tb_top
    import spcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic aclk = 1'b0;
    logic rst_n, ce, enhanced_pack, slow, wide_tready, narrow_tready, wide_tvalid;
    logic narrow_tvalid, pipe_valid, pipe_narrow;
    logic [31:0] wide_tdata, pipe_word, pack_acc;
    logic [7:0] narrow_tdata;
    logic [31:0] seed = 32'h0001_4310;
    logic [31:0] ew[$];
    logic [31:0] en[$];
    int n_fail = 0;
    int checked = 0;
    int lane = 0;
    logic ce_q = 1'b0;
    // Clocks: 2 ns phase offset keeps rising edges apart
    always #5 clk = ~clk;
    initial begin
        #2;
        forever #32 aclk = ~aclk;
    end
    spcb_app_src src (.aclk(aclk), .rst_n(rst_n), .slow(slow), .wide_tready(wide_tready),
        .narrow_tready(narrow_tready), .wide_tdata(wide_tdata), .wide_tvalid(wide_tvalid),
        .narrow_tdata(narrow_tdata), .narrow_tvalid(narrow_tvalid));
    spcb_bridge uut (.clk(clk), .rst_n(rst_n), .ce(ce), .application_clock_input(aclk),
        .enhanced_pack(enhanced_pack), .wide_tdata(wide_tdata), .wide_tvalid(wide_tvalid),
        .wide_tready(wide_tready), .narrow_tdata(narrow_tdata), .narrow_tvalid(narrow_tvalid),
        .narrow_tready(narrow_tready), .pipe_word(pipe_word), .pipe_valid(pipe_valid),
        .pipe_narrow(pipe_narrow), .generator_output_clock(), .generator_mul(),
        .generator_div());
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : lfsr
    // Expected slot: one byte alone, or four packed low lane first
    function automatic void push_b(input logic [7:0] b);
        src.nq.push_back(b);
        if (enhanced_pack) begin
            pack_acc[8*lane +: 8] = b;
            lane = (lane + 1) % 4;
            if (lane == 0) en.push_back(pack_acc);
        end else begin
            en.push_back({24'h00_0000, b});
        end
    endfunction : push_b
    task automatic mix(input int n);
        logic [31:0] r;
        repeat (n) begin
            r = lfsr();
            src.wq.push_back(r);
            ew.push_back(r);
            push_b(8'(lfsr() >> 24));
        end
    endtask : mix
    task automatic drain(input string name);
        int i;
        for (i = 0; i < 3000 && (ew.size() + en.size()) != 0; i++) begin
            @(posedge clk);
        end
        check(32'(ew.size() + en.size()), 32'h0000_0000);
        $display("Test %s done", name);
        if (i >= 3000) begin
            summarize();
        end
    endtask : drain
    task automatic summarize();
        $display("Counts: checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // Every transport word must be the next one its stream expects;
    // a word frozen by a low clock enable is counted only once
    always @(posedge clk) begin
        ce_q <= ce;
        if (pipe_valid === 1'b1 && ce_q) begin
            if ((pipe_narrow ? en.size() : ew.size()) == 0) begin
                check(32'h0000_0001, 32'h0000_0000);
            end else if (pipe_narrow) begin
                check(pipe_word, en.pop_front());
            end else begin
                check(pipe_word, ew.pop_front());
            end
        end
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        enhanced_pack = 1'b0;
        slow = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        src.wq.push_back(32'hffff_ffff);
        ew.push_back(32'hffff_ffff);
        push_b(8'hff);
        mix(8);
        drain("baseline");
        slow <= 1'b1;
        mix(6);
        drain("slow source");
        slow <= 1'b0;
        enhanced_pack <= 1'b1;
        repeat (40) @(posedge clk);
        push_b(8'h5a);
        push_b(8'ha5);
        push_b(8'h3c);
        repeat (300) @(posedge clk);
        mix(5);
        drain("packed");
        enhanced_pack <= 1'b0;
        repeat (40) @(posedge clk);
        ce <= 1'b0;
        mix(4);
        repeat (100) @(posedge clk);
        ce <= 1'b1;
        drain("clock enable");
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        mix(4);
        drain("second reset");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
